// ==== core/rsf_reset_flags.sv ====
// rsf_reset_flags: reset cause detection, sticky reset flags, status flags and post-reset init.
// assumes mode, command and code inputs come from core logic on REF_CLK; LOW_SUPPLY is asynchronous.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/100ps
module rsf_reset_flags (
	input  wire logic        REF_CLK,
	input  wire logic        ARST_N,
	input  wire logic [1:0]  REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [7:0]  REG_RDATA,
	input  wire logic        LOW_SUPPLY,
	input  wire logic        SLEEP_IDLE,
	input  wire logic        WDT_TIMEOUT,
	input  wire logic        CLR_WDT_CMD,
	input  wire logic        HALT_CMD,
	input  wire logic [7:0]  GUARD_CTRL,
	input  wire logic [4:0]  WDT_ENABLE_FIELD,
	output logic      [1:0]  LV_THRESHOLD_SEL,
	output logic             SYS_RESET,
	output logic             PCSP_CLEAR,
	output logic             TIMEOUT_FLAG,
	output logic             POWERDOWN_FLAG,
	output logic             INTR_DISABLE,
	output logic             WDT_RESTART,
	output logic             TIMER_OFF,
	output logic             PORTS_INPUT,
	output logic             SP_TO_TOP
);
	import rsf_pkg::*;

	// =====================================================================
	// decode functions
	function automatic logic thr_valid(input logic [7:0] code);
		thr_valid = (code == THR_CODE_LOWEST) || (code == THR_CODE_LOW) ||
		            (code == THR_CODE_HIGH) || (code == THR_CODE_HIGHEST);
	endfunction : thr_valid

	function automatic logic [1:0] thr_select(input logic [7:0] code);
		case (code)
			THR_CODE_LOW:     thr_select = 2'h1;
			THR_CODE_HIGH:    thr_select = 2'h2;
			THR_CODE_HIGHEST: thr_select = 2'h3;
			default:          thr_select = 2'h0;
		endcase
	endfunction : thr_select

	// =====================================================================
	// declarations
	rsf_state_t       state_q;
	rsf_state_t       state_d;
	logic             lv_s1_q;
	logic             lv_s2_q;
	logic [CNT_W-1:0] lv_cnt_q;
	logic [CNT_W-1:0] sw_cnt_q;
	logic [CNT_W-1:0] hold_cnt_q;
	logic [7:0]       thr_q;
	logic [3:0]       flags_q;
	logic [3:0]       flags_d;
	logic             to_q;
	logic             pdf_q;
	logic             pcsp_q;
	logic [1:0]       sel_q;
	logic [7:0]       rdata_q;
	logic             in_run;
	logic             guard_bad;
	logic             thr_bad;
	logic             wdt_bad;
	logic             sw_pend;
	logic             sw_trip;
	logic             lv_trip;
	logic             wdt_full;
	logic             wdt_sleep;
	logic             full_trip;
	logic             wr_flags;

	// =====================================================================
	// cause detection
	assign in_run    = (state_q == ST_RUN);
	assign guard_bad = (GUARD_CTRL != GUARD_NOP_A) && (GUARD_CTRL != GUARD_NOP_B);
	assign thr_bad   = !thr_valid(thr_q);
	assign wdt_bad   = (WDT_ENABLE_FIELD != WDT_EN_DISABLE) && (WDT_ENABLE_FIELD != WDT_EN_ENABLE);
	assign sw_pend   = guard_bad || thr_bad || wdt_bad;
	assign sw_trip   = in_run && sw_pend && (sw_cnt_q == SW_DLY_CNT);
	assign lv_trip   = in_run && !SLEEP_IDLE && lv_s2_q && (lv_cnt_q == LV_MIN_CNT);
	assign wdt_full  = in_run && WDT_TIMEOUT && !SLEEP_IDLE;
	assign wdt_sleep = in_run && WDT_TIMEOUT && SLEEP_IDLE;
	assign full_trip = lv_trip || sw_trip || wdt_full;
	assign wr_flags  = REG_WR && (REG_ADDR == ADDR_CAUSE_FLAGS);

	// low supply synchroniser
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			lv_s1_q <= 1'b0;
			lv_s2_q <= 1'b0;
		end else begin
			lv_s1_q <= LOW_SUPPLY;
			lv_s2_q <= lv_s1_q;
		end
	end

	// low supply duration filter, idle while in sleep
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			lv_cnt_q <= CNT_ZERO;
		end else if (!lv_s2_q || SLEEP_IDLE) begin
			lv_cnt_q <= CNT_ZERO;
		end else if (lv_cnt_q != LV_MIN_CNT) begin
			lv_cnt_q <= lv_cnt_q + CNT_ONE;
		end
	end

	// software reset delay, cancelled if the bad code goes away
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sw_cnt_q <= CNT_ZERO;
		end else if (!sw_pend || !in_run) begin
			sw_cnt_q <= CNT_ZERO;
		end else if (sw_cnt_q != SW_DLY_CNT) begin
			sw_cnt_q <= sw_cnt_q + CNT_ONE;
		end
	end

	// =====================================================================
	// reset sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_INIT: state_d = ST_RUN;
			ST_RUN: begin
				if (full_trip) begin
					state_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if ((hold_cnt_q == HOLD_LAST) && !lv_s2_q) begin
					state_d = ST_INIT;
				end
			end
			default: state_d = ST_INIT;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_q <= ST_INIT;
		end else begin
			state_q <= state_d;
		end
	end

	// reset hold length counter
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			hold_cnt_q <= CNT_ZERO;
		end else if (state_q != ST_HOLD) begin
			hold_cnt_q <= CNT_ZERO;
		end else if (hold_cnt_q != HOLD_LAST) begin
			hold_cnt_q <= hold_cnt_q + CNT_ONE;
		end
	end

	// init and reset outputs come from state flops
	assign SYS_RESET    = state_q[2];
	assign INTR_DISABLE = state_q[0];
	assign WDT_RESTART  = state_q[0];
	assign TIMER_OFF    = state_q[0];
	assign PORTS_INPUT  = state_q[0];
	assign SP_TO_TOP    = state_q[0];

	// sleep timeout partial reset pulse
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pcsp_q <= 1'b0;
		end else begin
			pcsp_q <= wdt_sleep;
		end
	end
	assign PCSP_CLEAR = pcsp_q;

	// =====================================================================
	// reset cause flags: hardware set wins over software clear
	always_comb begin
		flags_d = flags_q;
		if (wr_flags) begin
			flags_d = flags_q & REG_WDATA[3:0];
		end
		if (sw_trip && guard_bad) begin
			flags_d[BIT_CTRL_SW_RST] = 1'b1;
		end
		if (lv_trip) begin
			flags_d[BIT_LOW_VOLT_RST] = 1'b1;
		end
		if (sw_trip && thr_bad) begin
			flags_d[BIT_THR_REG_RST] = 1'b1;
		end
		if (sw_trip && wdt_bad) begin
			flags_d[BIT_WDT_CTRL_RST] = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			flags_q <= FLAGS_POR;
		end else begin
			flags_q <= flags_d;
		end
	end

	// threshold select register, kept over a low voltage reset
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			thr_q <= THR_POR;
		end else if (sw_trip && thr_bad) begin
			thr_q <= THR_POR;
		end else if (REG_WR && (REG_ADDR == ADDR_THRESHOLD)) begin
			thr_q <= REG_WDATA;
		end
	end

	// registered threshold selection; holds last valid choice on a bad code
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sel_q <= 2'h0;
		end else if (!thr_bad) begin
			sel_q <= thr_select(thr_q);
		end
	end
	assign LV_THRESHOLD_SEL = sel_q;

	// =====================================================================
	// timeout and powerdown status flags
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			to_q  <= 1'b0;
			pdf_q <= 1'b0;
		end else begin
			if (wdt_full || wdt_sleep) begin
				to_q <= 1'b1;
			end else if (CLR_WDT_CMD || HALT_CMD) begin
				to_q <= 1'b0;
			end
			if (wdt_sleep || HALT_CMD) begin
				pdf_q <= 1'b1;
			end else if (CLR_WDT_CMD) begin
				pdf_q <= 1'b0;
			end
		end
	end
	assign TIMEOUT_FLAG   = to_q;
	assign POWERDOWN_FLAG = pdf_q;

	// =====================================================================
	// register read port, data one cycle after the strobe
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rdata_q <= BYTE_ZERO;
		end else if (REG_RD) begin
			case (REG_ADDR)
				ADDR_CAUSE_FLAGS: rdata_q <= {4'h0, flags_q};
				ADDR_THRESHOLD:   rdata_q <= thr_q;
				ADDR_STATUS:      rdata_q <= {6'h00, to_q, pdf_q};
				default:          rdata_q <= BYTE_ZERO;
			endcase
		end else begin
			rdata_q <= BYTE_ZERO;
		end
	end
	assign REG_RDATA = rdata_q;

	// =====================================================================
	// checks
	sequence s_sw_expire;
		in_run && sw_pend && (sw_cnt_q == SW_DLY_CNT);
	endsequence

	sequence s_enter_hold;
		SYS_RESET ##1 SYS_RESET;
	endsequence

	property p_guard_flag;
		@(posedge REF_CLK) disable iff (!ARST_N)
		(s_sw_expire and guard_bad) |=> flags_q[BIT_CTRL_SW_RST] ##0 s_enter_hold;
	endproperty
	a_guard_flag: assert property (p_guard_flag) else $error("guarded control reset missed");

	property p_upper_zero;
		@(posedge REF_CLK) disable iff (!ARST_N)
		(REG_RD && (REG_ADDR == ADDR_CAUSE_FLAGS)) |=> (REG_RDATA[7:4] == 4'h0) && (REG_RDATA[3:0] == $past(flags_q));
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("flag readback wrong");

	property p_lv_reset;
		@(posedge REF_CLK) disable iff (!ARST_N)
		lv_trip |=> flags_q[BIT_LOW_VOLT_RST] && SYS_RESET && (thr_q == $past(thr_q) || $past(REG_WR));
	endproperty
	a_lv_reset: assert property (p_lv_reset) else $error("low voltage reset wrong");

	property p_lv_short;
		@(posedge REF_CLK) disable iff (!ARST_N)
		!lv_s2_q |=> (lv_cnt_q == CNT_ZERO);
	endproperty
	a_lv_short: assert property (p_lv_short) else $error("short low supply caused reset");

	property p_thr_reload;
		@(posedge REF_CLK) disable iff (!ARST_N)
		(s_sw_expire and thr_bad) |=> (thr_q == THR_POR) && flags_q[BIT_THR_REG_RST] && SYS_RESET;
	endproperty
	a_thr_reload: assert property (p_thr_reload) else $error("bad threshold not handled");

	property p_sleep_no_lv;
		@(posedge REF_CLK) disable iff (!ARST_N)
		SLEEP_IDLE |=> (lv_cnt_q == CNT_ZERO);
	endproperty
	a_sleep_no_lv: assert property (p_sleep_no_lv) else $error("low voltage trip in sleep");

	property p_flag_sticky;
		@(posedge REF_CLK) disable iff (!ARST_N)
		(flags_q[BIT_LOW_VOLT_RST] && !(wr_flags && !REG_WDATA[BIT_LOW_VOLT_RST])) |=> flags_q[BIT_LOW_VOLT_RST];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("low voltage flag lost");

	property p_wdt_run;
		@(posedge REF_CLK) disable iff (!ARST_N)
		wdt_full |=> TIMEOUT_FLAG && SYS_RESET && !PCSP_CLEAR;
	endproperty
	a_wdt_run: assert property (p_wdt_run) else $error("run timeout reset wrong");

	property p_wdt_sleep;
		@(posedge REF_CLK) disable iff (!ARST_N)
		wdt_sleep |=> PCSP_CLEAR && TIMEOUT_FLAG && POWERDOWN_FLAG && !SYS_RESET ##1 !PCSP_CLEAR;
	endproperty
	a_wdt_sleep: assert property (p_wdt_sleep) else $error("sleep timeout reset wrong");

	property p_init_once;
		@(posedge REF_CLK) disable iff (!ARST_N)
		$fell(SYS_RESET) |-> INTR_DISABLE && TIMER_OFF && PORTS_INPUT && SP_TO_TOP ##1 !WDT_RESTART;
	endproperty
	a_init_once: assert property (p_init_once) else $error("post reset init wrong");

endmodule : rsf_reset_flags

// ==== pkg/rsf_pkg.sv ====
// rsf_pkg: constants, register map and state codes for the reset source and flag logic.
// assumes a 10 MHz system clock and a plain one-cycle register port.
package rsf_pkg;

	// =====================================================================
	// clock and timing
	localparam int CLK_PERIOD_NS          = 100;
	localparam int SW_RESET_DELAY_NS      = 48000;  // software_reset_delay, least time
	localparam int LV_MIN_DURATION_NS     = 120000; // low_voltage_min_duration, least time
	localparam int SW_RESET_DELAY_CYC     = (SW_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LV_MIN_DURATION_CYC    = (LV_MIN_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_HOLD_CYC         = 4;
	localparam int CNT_W                  = 12;
	localparam logic [CNT_W-1:0] SW_DLY_CNT  = CNT_W'(SW_RESET_DELAY_CYC);
	localparam logic [CNT_W-1:0] LV_MIN_CNT  = CNT_W'(LV_MIN_DURATION_CYC);
	localparam logic [CNT_W-1:0] HOLD_LAST   = CNT_W'(RESET_HOLD_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ONE     = 12'h001;
	localparam logic [CNT_W-1:0] CNT_ZERO    = 12'h000;

	// =====================================================================
	// register map
	localparam logic [1:0] ADDR_CAUSE_FLAGS = 2'h0; // reset_cause_flags
	localparam logic [1:0] ADDR_THRESHOLD   = 2'h1; // low_voltage_threshold_select
	localparam logic [1:0] ADDR_STATUS      = 2'h2; // timeout and powerdown status
	localparam int BIT_CTRL_SW_RST   = 3;
	localparam int BIT_LOW_VOLT_RST  = 2;
	localparam int BIT_THR_REG_RST   = 1;
	localparam int BIT_WDT_CTRL_RST  = 0;
	localparam int BIT_TIMEOUT       = 1;
	localparam int BIT_POWERDOWN     = 0;
	localparam logic [3:0] FLAGS_POR = 4'h0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// =====================================================================
	// codes
	localparam logic [7:0] THR_CODE_LOWEST  = 8'h55;
	localparam logic [7:0] THR_CODE_LOW     = 8'h33;
	localparam logic [7:0] THR_CODE_HIGH    = 8'h99;
	localparam logic [7:0] THR_CODE_HIGHEST = 8'haa;
	localparam logic [7:0] THR_POR          = 8'h55;
	localparam logic [7:0] GUARD_NOP_A      = 8'h55;
	localparam logic [7:0] GUARD_NOP_B      = 8'haa;
	localparam logic [4:0] WDT_EN_DISABLE   = 5'h15;
	localparam logic [4:0] WDT_EN_ENABLE    = 5'h0a;

	typedef enum logic [2:0] {
		ST_INIT = 3'h1,
		ST_RUN  = 3'h2,
		ST_HOLD = 3'h4
	} rsf_state_t;

endpackage : rsf_pkg

// ==== sim/rsf_core_model.sv ====
// rsf_core_model: core side guarded registers and supply comparator for the reset flag block.
// assumes one clock; the bench loads codes with one-cycle set pulses and asks for low supply by level.
`timescale 1ns/100ps
module rsf_core_model
	import rsf_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       sys_reset,
	input  wire logic       set_req,
	input  wire logic [7:0] guard_val,
	input  wire logic [4:0] wdt_val,
	input  wire logic       lv_req,
	output logic      [7:0] guard_ctrl,
	output logic      [4:0] wdt_field,
	output logic            low_supply
);
	// =====================================================================
	// guarded registers; a full reset brings back the GUARD_NOP_A and WDT_EN_ENABLE codes
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n || sys_reset) begin
			guard_ctrl <= GUARD_NOP_A;
			wdt_field  <= WDT_EN_ENABLE;
		end else if (set_req) begin
			guard_ctrl <= guard_val;
			wdt_field  <= wdt_val;
		end
	end

	// =====================================================================
	// comparator output follows the requested supply level
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			low_supply <= 1'b0;
		end else begin
			low_supply <= lv_req;
		end
	end
endmodule : rsf_core_model

// ==== sim/rsf_reset_flags_tb.sv ====
// rsf_reset_flags_tb: self-checking bench for the reset source and flag logic.
// assumes the package delays and a 10 MHz clock; stimulus at rising edges.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin err_count++; \
	$display("Error %s expected %h seen %h", nm, ex, gt); end end
module rsf_reset_flags_tb;
	import rsf_pkg::*;
	logic       ref_clk, arst_n, reg_wr, reg_rd, sleep_idle, wdt_timeout, clr_wdt_cmd, halt_cmd;
	logic       low_supply, sys_reset, pcsp_clear, timeout_flag, powerdown_flag, set_req, lv_req;
	logic       intr_disable, wdt_restart, timer_off, ports_input, sp_to_top;
	logic [1:0] reg_addr, lv_threshold_sel;
	logic [7:0] reg_wdata, reg_rdata, guard_ctrl, guard_val, rd_d, code;
	logic [4:0] wdt_enable_field, wdt_val, init_o;
	logic [2:0] e;
	logic [31:0] rng;
	int         err_count, cmp_count, n;
	logic [7:0] codes [4] = '{THR_CODE_HIGHEST, THR_CODE_LOW, THR_CODE_HIGH, THR_CODE_LOWEST};
	assign init_o = {intr_disable, wdt_restart, timer_off, ports_input, sp_to_top};

	// =====================================================================
	// design and core side model
	rsf_reset_flags dut (.REF_CLK(ref_clk), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .LOW_SUPPLY(low_supply),
		.SLEEP_IDLE(sleep_idle), .WDT_TIMEOUT(wdt_timeout), .CLR_WDT_CMD(clr_wdt_cmd), .HALT_CMD(halt_cmd),
		.GUARD_CTRL(guard_ctrl), .WDT_ENABLE_FIELD(wdt_enable_field), .LV_THRESHOLD_SEL(lv_threshold_sel),
		.SYS_RESET(sys_reset), .PCSP_CLEAR(pcsp_clear), .TIMEOUT_FLAG(timeout_flag),
		.POWERDOWN_FLAG(powerdown_flag), .INTR_DISABLE(intr_disable), .WDT_RESTART(wdt_restart),
		.TIMER_OFF(timer_off), .PORTS_INPUT(ports_input), .SP_TO_TOP(sp_to_top));
	rsf_core_model core (.clk(ref_clk), .arst_n(arst_n), .sys_reset(sys_reset), .set_req(set_req),
		.guard_val(guard_val), .wdt_val(wdt_val), .lv_req(lv_req), .guard_ctrl(guard_ctrl),
		.wdt_field(wdt_enable_field), .low_supply(low_supply));

	// =====================================================================
	// expectation helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		t = t ^ (t << 5);
		return t;
	endfunction : xs
	// valid bit and select index of a threshold code
	function automatic logic [2:0] exp_sel(input logic [7:0] c);
		case (c)
			8'h55: return 3'h4;
			8'h33: return 3'h5;
			8'h99: return 3'h6;
			8'haa: return 3'h7;
			default: return 3'h0;
		endcase
	endfunction : exp_sel

	// =====================================================================
	// register port and event tasks
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task chk_rd(input string nm, input logic [1:0] a, input logic [7:0] ex);
		@(posedge ref_clk);
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		rd_d = reg_rdata;
		`CHK(nm, ex, rd_d)
	endtask : chk_rd
	task ticks(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : ticks
	task wait_hi(input int lim);
		n = 0;
		while (sys_reset !== 1'b1 && n < lim) begin
			@(negedge ref_clk);
			n++;
		end
		`CHK("sys_reset_rise", 1'b1, sys_reset)
	endtask : wait_hi
	// init pulse for one cycle, in the cycle that full reset ends
	task wait_end;
		n = 0;
		while (sys_reset !== 1'b0 && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		`CHK("init_on", 5'h1f, init_o)
		@(negedge ref_clk);
		`CHK("init_off", 5'h00, init_o)
	endtask : wait_end
	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict

	// =====================================================================
	// clock and watchdog
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		#2000000;
		err_count++;
		give_verdict();
	end

	// =====================================================================
	// main sequence
	initial begin
		err_count = 0; cmp_count = 0; rng = 32'd32220; arst_n = 1'b0;
		reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 2'h0; reg_wdata = 8'h00; sleep_idle = 1'b0;
		wdt_timeout = 1'b0; clr_wdt_cmd = 1'b0; halt_cmd = 1'b0; set_req = 1'b0; lv_req = 1'b0;
		guard_val = GUARD_NOP_A; wdt_val = WDT_EN_ENABLE;
		repeat (4) @(negedge ref_clk);
		`CHK("init_por", 5'h1f, init_o)
		@(posedge ref_clk) arst_n <= 1'b1;
		ticks(2);
		chk_rd("flags_por", ADDR_CAUSE_FLAGS, 8'h00);
		chk_rd("thr_por", ADDR_THRESHOLD, THR_POR);
		chk_rd("status_por", ADDR_STATUS, 8'h00);
		chk_rd("unmapped", 2'h3, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_THRESHOLD, codes[i]);
			e = exp_sel(codes[i]);
			ticks(1);
			@(negedge ref_clk) `CHK("thr_sel", e[1:0], lv_threshold_sel)
			chk_rd("thr_back", ADDR_THRESHOLD, codes[i]);
		end
		wr(ADDR_CAUSE_FLAGS, 8'hff);
		chk_rd("flags_ones", ADDR_CAUSE_FLAGS, 8'h00);
		@(posedge ref_clk) halt_cmd <= 1'b1;
		@(posedge ref_clk) halt_cmd <= 1'b0;
		// short random low supply is filtered out
		rng = xs(rng);
		@(posedge ref_clk) lv_req <= 1'b1;
		ticks(900 + int'(rng[7:0]));
		lv_req <= 1'b0;
		ticks(6);
		`CHK("lv_short", 1'b0, sys_reset)
		wr(ADDR_THRESHOLD, THR_CODE_HIGH);
		@(posedge ref_clk) lv_req <= 1'b1;
		wait_hi(1300);
		`CHK("lv_late", 1'b1, n > LV_MIN_DURATION_CYC)
		@(posedge ref_clk) lv_req <= 1'b0;
		wait_end();
		chk_rd("lv_flag", ADDR_CAUSE_FLAGS, 8'h04);
		chk_rd("lv_thr", ADDR_THRESHOLD, THR_CODE_HIGH);
		chk_rd("lv_status", ADDR_STATUS, 8'h01);
		wr(ADDR_CAUSE_FLAGS, 8'h00);
		chk_rd("lv_clear", ADDR_CAUSE_FLAGS, 8'h00);
		// low supply ignored while sleeping, then a sleep timeout
		@(posedge ref_clk) sleep_idle <= 1'b1;
		lv_req <= 1'b1;
		ticks(1400);
		`CHK("lv_sleep", 1'b0, sys_reset)
		lv_req <= 1'b0;
		ticks(4);
		wdt_timeout <= 1'b1;
		@(posedge ref_clk) wdt_timeout <= 1'b0;
		@(negedge ref_clk) `CHK("pcsp", 4'b1011, {pcsp_clear, sys_reset, timeout_flag, powerdown_flag})
		chk_rd("sleep_status", ADDR_STATUS, 8'h03);
		@(posedge ref_clk) sleep_idle <= 1'b0;
		clr_wdt_cmd <= 1'b1;
		@(posedge ref_clk) clr_wdt_cmd <= 1'b0;
		wdt_timeout <= 1'b1;
		@(posedge ref_clk) wdt_timeout <= 1'b0;
		@(negedge ref_clk) `CHK("run_to", 2'b11, {sys_reset, timeout_flag})
		wait_end();
		chk_rd("run_status", ADDR_STATUS, 8'h02);
		// bad threshold, guarded control and watchdog field codes
		for (int k = 0; k < 3; k++) begin
			do begin
				rng = xs(rng);
				code = rng[15:8];
			end while (exp_sel(code) != 3'h0 || code[4:0] == WDT_EN_DISABLE || code[4:0] == WDT_EN_ENABLE);
			if (k == 0) begin
				wr(ADDR_THRESHOLD, code);
			end else begin
				@(posedge ref_clk) set_req <= 1'b1;
				guard_val <= (k == 1) ? code : GUARD_NOP_B;
				wdt_val <= (k == 2) ? code[4:0] : WDT_EN_DISABLE;
				@(posedge ref_clk) set_req <= 1'b0;
			end
			ticks(470);
			`CHK("sw_early", 1'b0, sys_reset)
			wait_hi(40);
			wait_end();
			chk_rd("sw_flag", ADDR_CAUSE_FLAGS, (k == 0) ? 8'h02 : (k == 1) ? 8'h08 : 8'h01);
			chk_rd("sw_thr", ADDR_THRESHOLD, THR_POR);
			wr(ADDR_CAUSE_FLAGS, 8'h00);
		end
		`CHK("thr_sel_por", 2'h0, lv_threshold_sel)
		give_verdict();
	end
endmodule : rsf_reset_flags_tb
